//--- rtl/esdp_pkg.sv
// Constants, types and helpers of the external strobe data port.
// Assumes one system clock of 10 MHz and an 8-bit register port.
// What this block does
// R1: Strobe-enable bits of extension control pick the external data register mode.
// R2: Both clear: upper nibble scratchpad, low nibble returns four voltage-sense levels.
// R3: Read-strobe only: register read pulses socket B strobe, data taken from SD[15:8].
// R4: Write-strobe only: write pulses socket B strobe latching SD[15:8]; reads return it.
// R5: Polarity bit clear makes strobes active-low, set makes them active-high.
// R6: Write-strobe bit clear: socket A pin senses voltage; set: strobes upper-byte writes.
// R7: Read-strobe bit clear: socket B pin senses voltage; set: strobes upper-byte reads. The code also drives socket B in write-strobe-only mode.
// R8: A set strobe-enable bit forces that pin's pull-up off, whatever pull-up control says.
// R9: Drive bit clear gives open-collector strobes; set gives actively driven highs.
// R10: Card timing register writes take effect at once.
// R11: Software should change timing registers only while the write FIFO is empty.
// R12: Window control timing-select bits pick timing set 0 or 1 per window.
// R13: Software should use socket B external data only as a read port.
// R14: Software should touch only the low nibble of external data.
// R15: Both strobe-enables set: no strobes, scratchpad behaviour; reserved bits read back.
package esdp_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_PULLUP = 8'h03;
  localparam logic [7:0] ADDR_WINCTL = 8'h07;
  localparam logic [7:0] ADDR_EXT_DATA = 8'h0a;
  localparam logic [7:0] ADDR_EXT_CTRL = 8'h0b;
  localparam logic [7:0] ADDR_TIMING = 8'h3a;
  localparam int TIMING_REGS = 6;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POL_BIT = 5;
  localparam int WSE_BIT = 4;
  localparam int RSE_BIT = 3;
  localparam int DRV_BIT = 2;
  localparam int PULLUP_BIT = 5;
  localparam int WIN0_SEL_BIT = 3;
  localparam int WIN1_SEL_BIT = 7;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] EXT_DATA_RST = 8'h00;
  localparam logic [7:0] EXT_CTRL_RST = 8'h00;
  localparam logic [7:0] PULLUP_RST = 8'h00;
  localparam logic [7:0] WINCTL_RST = 8'h00;
  localparam logic [7:0] SETUP_RST = 8'h01;
  localparam logic [7:0] CMD0_RST = 8'h06;
  localparam logic [7:0] CMD1_RST = 8'h0f;
  localparam logic [7:0] RECOV_RST = 8'h03;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 100;
  localparam int STROBE_NS = 200;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] WR_PULSE_CYC = 4'(STROBE_CYC);
  localparam logic [3:0] RD_PULSE_CYC = 4'(STROBE_CYC + SYNC_STAGES + 1);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_SCRATCH = 2'b00,
    MODE_READ = 2'b01,
    MODE_WRITE = 2'b10,
    MODE_RSVD = 2'b11
  } esdp_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_PULSE = 2'b11,
    ST_HOLD = 2'b10
  } esdp_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } esdp_req_t;

  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] command;
    logic [7:0] recovery;
  } esdp_timing_t;

  // Mode from the two strobe-enable bits
  function automatic esdp_mode_t mode_of(input logic [7:0] ctrl);
    return esdp_mode_t'({ctrl[WSE_BIT], ctrl[RSE_BIT]});
  endfunction

  // Reset value of timing register i
  function automatic logic [7:0] timing_rst(input int i);
    case (i % 3)
      0: return SETUP_RST;
      1: return (i < 3) ? CMD0_RST : CMD1_RST;
      default: return RECOV_RST;
    endcase
  endfunction

endpackage

//--- rtl/esdp_sync.sv
// Two-stage synchroniser for levels arriving from pins.
// Assumes asynchronous inputs and the system clock domain.
`timescale 1ns/100ps
module esdp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage is read only by the second
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= '0;
      q <= '0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

//--- rtl/esdp_pin.sv
// Output stage of one general strobe pin: polarity, drive and pull-up.
// Assumes the board resolves the wire from out and oe.
`timescale 1ns/100ps
module esdp_pin (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  // Control
  input wire logic act,
  input wire logic is_out,
  input wire logic pol_high,
  input wire logic totem,
  input wire logic pull_en,
  // Pin
  output logic pin_out,
  output logic pin_oe,
  output logic pin_pullup
);

  logic level;

  // Electrical level of the strobe
  assign level = pol_high ? act : ~act; // R5

  // Registered pin drive
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else if (ce) begin
      pin_out <= level;
      pin_oe <= is_out & (~level | totem); // R9
    end
  end

  // Registered pull-up enable
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_pullup <= 1'b0;
    end else if (ce) begin
      pin_pullup <= pull_en;
    end
  end

endmodule

//--- rtl/esdp_top.sv
// External strobe data port: registers, strobe sequencer and pin stages.
// Assumes a register master on clk_sys and an external latch or
// read buffer on the upper system data byte, enabled by the strobes.
`timescale 1ns/100ps
module esdp_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  // Register port
  input wire esdp_pkg::esdp_req_t bus_req,
  output logic [7:0] rdata,
  // Upper system data byte
  input wire logic [7:0] sd_hi_in,
  output logic [7:0] sd_hi_out,
  output logic sd_hi_oe,
  // Socket A strobe pin
  input wire logic socket_a_strobe_pin_in,
  output logic socket_a_strobe_pin_out,
  output logic socket_a_strobe_pin_oe,
  output logic socket_a_strobe_pullup,
  // Socket B strobe pin
  input wire logic socket_b_strobe_pin_in,
  output logic socket_b_strobe_pin_out,
  output logic socket_b_strobe_pin_oe,
  output logic socket_b_strobe_pullup,
  // Second voltage-sense inputs
  input wire logic socket_a_sense_two_n,
  input wire logic socket_b_sense_two_n,
  // Card cycle timing
  input wire logic cycle_window,
  output esdp_pkg::esdp_timing_t cycle_timing
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] pullup_r;
  logic [7:0] winctl_r;
  logic [7:0] tm_r [esdp_pkg::TIMING_REGS];
  logic [3:0] scratch_r;
  logic [7:0] latch_r;
  logic [7:0] capt_r;
  logic [7:0] sd_out_r;
  logic sd_oe_r;
  logic [7:0] rdata_r;
  logic [3:0] cnt_r;
  logic dir_wr_r;
  esdp_pkg::esdp_state_t state_r;
  esdp_pkg::esdp_timing_t timing_r;
  esdp_pkg::esdp_mode_t mode;
  logic [7:0] sd_sync;
  logic [3:0] sense_sync;
  logic [3:0] sense_vec;
  logic rd_ext;
  logic wr_ext;
  logic start_rd;
  logic start_wr;
  logic act_a;
  logic act_b;
  logic out_a;
  logic out_b;
  logic [7:0] winctl_fwd;
  logic sel_set1;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Upper data byte from the external buffer
  esdp_sync #(.W(8)) u_sync_sd (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .d(sd_hi_in),
    .q(sd_sync)
  );

  // Sense levels: strobe pins double as first sense input
  esdp_sync #(.W(4)) u_sync_sense (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .d({socket_b_sense_two_n, socket_b_strobe_pin_in,
        socket_a_sense_two_n, socket_a_strobe_pin_in}),
    .q(sense_sync)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Mode and register hits
  assign mode = esdp_pkg::mode_of(ctrl_r); // R1
  assign rd_ext = bus_req.rd && (bus_req.addr == esdp_pkg::ADDR_EXT_DATA);
  assign wr_ext = bus_req.wr && (bus_req.addr == esdp_pkg::ADDR_EXT_DATA);
  assign sense_vec = sense_sync; // R2

  // Strobe requests; reserved mode starts none
  assign start_rd = rd_ext && (mode == esdp_pkg::MODE_READ) && (state_r == esdp_pkg::ST_IDLE); // R3
  assign start_wr = wr_ext && (mode == esdp_pkg::MODE_WRITE) && (state_r == esdp_pkg::ST_IDLE); // R4 R15

  // Timing register hit test
  function automatic logic tm_hit(input int i);
    return bus_req.wr && (bus_req.addr == 8'(esdp_pkg::ADDR_TIMING + i));
  endfunction

  // Timing value with this cycle's write forwarded
  function automatic logic [7:0] tm_fwd(input int i);
    return tm_hit(i) ? bus_req.wdata : tm_r[i];
  endfunction

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Extension control, all bits stored as written
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= esdp_pkg::EXT_CTRL_RST;
    end else if (ce && bus_req.wr && bus_req.addr == esdp_pkg::ADDR_EXT_CTRL) begin
      ctrl_r <= bus_req.wdata; // R15
    end
  end

  // Pull-up control
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pullup_r <= esdp_pkg::PULLUP_RST;
    end else if (ce && bus_req.wr && bus_req.addr == esdp_pkg::ADDR_PULLUP) begin
      pullup_r <= bus_req.wdata;
    end
  end

  // Window control with timing-select bits
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      winctl_r <= esdp_pkg::WINCTL_RST;
    end else if (ce && bus_req.wr && bus_req.addr == esdp_pkg::ADDR_WINCTL) begin
      winctl_r <= bus_req.wdata;
    end
  end

  // Timing registers, two sets of setup, command, recovery
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < esdp_pkg::TIMING_REGS; i++) begin
        tm_r[i] <= esdp_pkg::timing_rst(i);
      end
    end else if (ce) begin
      for (int i = 0; i < esdp_pkg::TIMING_REGS; i++) begin
        if (tm_hit(i)) begin
          tm_r[i] <= bus_req.wdata; // R10
        end
      end
    end
  end

  // ----------------------------------------
  // Timing set selection
  // ----------------------------------------
  // Window control forwarded so a write applies at once
  always_comb begin
    winctl_fwd = winctl_r;
    if (bus_req.wr && bus_req.addr == esdp_pkg::ADDR_WINCTL) begin
      winctl_fwd = bus_req.wdata; // R10
    end
    sel_set1 = cycle_window ? winctl_fwd[esdp_pkg::WIN1_SEL_BIT]
                            : winctl_fwd[esdp_pkg::WIN0_SEL_BIT]; // R12
  end

  // Timing values for the current card cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      timing_r <= {esdp_pkg::SETUP_RST, esdp_pkg::CMD0_RST, esdp_pkg::RECOV_RST};
    end else if (ce) begin
      if (sel_set1) begin
        timing_r <= {tm_fwd(3), tm_fwd(4), tm_fwd(5)}; // R12
      end else begin
        timing_r <= {tm_fwd(0), tm_fwd(1), tm_fwd(2)}; // R12
      end
    end
  end

  // ----------------------------------------
  // External data storage
  // ----------------------------------------
  // Scratchpad nibble, written outside the port modes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      scratch_r <= esdp_pkg::EXT_DATA_RST[7:4];
    end else if (ce && wr_ext) begin
      if (mode == esdp_pkg::MODE_SCRATCH || mode == esdp_pkg::MODE_RSVD) begin
        scratch_r <= bus_req.wdata[7:4]; // R2 R15
      end
    end
  end

  // Copy of the value sent to the external latch
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      latch_r <= esdp_pkg::EXT_DATA_RST;
    end else if (ce && wr_ext && mode == esdp_pkg::MODE_WRITE) begin
      latch_r <= bus_req.wdata; // R4
    end
  end

  // Data taken from the read buffer at the end of a read strobe
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      capt_r <= esdp_pkg::EXT_DATA_RST;
    end else if (ce && state_r == esdp_pkg::ST_PULSE && !dir_wr_r && cnt_r == 4'h0) begin
      capt_r <= sd_sync; // R3
    end
  end

  // ----------------------------------------
  // Strobe sequencer
  // ----------------------------------------
  // Setup, pulse and hold around each external access
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= esdp_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      dir_wr_r <= 1'b0;
    end else if (ce) begin
      case (state_r)
        esdp_pkg::ST_IDLE: begin
          if (start_rd) begin
            state_r <= esdp_pkg::ST_SETUP; // R3
            cnt_r <= esdp_pkg::RD_PULSE_CYC - 4'h1;
            dir_wr_r <= 1'b0;
          end else if (start_wr) begin
            state_r <= esdp_pkg::ST_SETUP; // R4
            cnt_r <= esdp_pkg::WR_PULSE_CYC - 4'h1;
            dir_wr_r <= 1'b1;
          end
        end
        esdp_pkg::ST_SETUP: begin
          state_r <= esdp_pkg::ST_PULSE;
        end
        esdp_pkg::ST_PULSE: begin
          if (cnt_r == 4'h0) begin
            state_r <= esdp_pkg::ST_HOLD;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        esdp_pkg::ST_HOLD: begin
          state_r <= esdp_pkg::ST_IDLE;
        end
        default: begin
          state_r <= esdp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Upper byte drive, set up before and held after the strobe
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sd_out_r <= 8'h00;
      sd_oe_r <= 1'b0;
    end else if (ce) begin
      if (start_wr) begin
        sd_out_r <= bus_req.wdata; // R4
      end
      sd_oe_r <= dir_wr_r && (state_r != esdp_pkg::ST_IDLE);
    end
  end

  // Strobe activity and pin roles
  assign act_b = (state_r == esdp_pkg::ST_PULSE); // R3 R4
  assign act_a = act_b && dir_wr_r; // R6
  assign out_a = ctrl_r[esdp_pkg::WSE_BIT]; // R6
  assign out_b = ctrl_r[esdp_pkg::RSE_BIT] || (mode == esdp_pkg::MODE_WRITE); // R7

  // ----------------------------------------
  // Pin stages
  // ----------------------------------------
  // Socket A strobe pin
  esdp_pin u_pin_a (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .act(act_a),
    .is_out(out_a),
    .pol_high(ctrl_r[esdp_pkg::POL_BIT]),
    .totem(ctrl_r[esdp_pkg::DRV_BIT]),
    .pull_en(pullup_r[esdp_pkg::PULLUP_BIT] && !ctrl_r[esdp_pkg::WSE_BIT]), // R8
    .pin_out(socket_a_strobe_pin_out),
    .pin_oe(socket_a_strobe_pin_oe),
    .pin_pullup(socket_a_strobe_pullup)
  );

  // Socket B strobe pin
  esdp_pin u_pin_b (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .act(act_b),
    .is_out(out_b),
    .pol_high(ctrl_r[esdp_pkg::POL_BIT]),
    .totem(ctrl_r[esdp_pkg::DRV_BIT]),
    .pull_en(pullup_r[esdp_pkg::PULLUP_BIT] && !ctrl_r[esdp_pkg::RSE_BIT]), // R8
    .pin_out(socket_b_strobe_pin_out),
    .pin_oe(socket_b_strobe_pin_oe),
    .pin_pullup(socket_b_strobe_pullup)
  );

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Read mux, answered in the cycle after the read request
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else if (ce) begin
      rdata_r <= 8'h00;
      if (bus_req.rd) begin
        case (bus_req.addr)
          esdp_pkg::ADDR_EXT_DATA: begin
            case (mode)
              esdp_pkg::MODE_READ: rdata_r <= capt_r; // R3
              esdp_pkg::MODE_WRITE: rdata_r <= latch_r; // R4
              default: rdata_r <= {scratch_r, sense_vec}; // R2 R15
            endcase
          end
          esdp_pkg::ADDR_EXT_CTRL: rdata_r <= ctrl_r;
          esdp_pkg::ADDR_PULLUP: rdata_r <= pullup_r;
          esdp_pkg::ADDR_WINCTL: rdata_r <= winctl_r;
          default: begin
            for (int i = 0; i < esdp_pkg::TIMING_REGS; i++) begin
              if (bus_req.addr == 8'(esdp_pkg::ADDR_TIMING + i)) begin
                rdata_r <= tm_r[i];
              end
            end
          end
        endcase
      end
    end
  end

  assign rdata = rdata_r;
  assign sd_hi_out = sd_out_r;
  assign sd_hi_oe = sd_oe_r;
  assign cycle_timing = timing_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst || !ce);

  // Read and write strobe sequences
  sequence s_rd_pulse;
    (state_r == esdp_pkg::ST_SETUP) ##1 (state_r == esdp_pkg::ST_PULSE) [*5]
      ##1 (state_r == esdp_pkg::ST_HOLD);
  endsequence

  sequence s_wr_pulse;
    (state_r == esdp_pkg::ST_SETUP) ##1 (state_r == esdp_pkg::ST_PULSE) [*2]
      ##1 (state_r == esdp_pkg::ST_HOLD);
  endsequence

  chk_mode_scratch_read: assert property ( // R2
    (rd_ext && mode == esdp_pkg::MODE_SCRATCH) |=> (rdata == {$past(scratch_r), $past(sense_vec)}))
    else $error("scratchpad read returned wrong data");

  chk_read_strobe_seq: assert property ( // R3
    start_rd |=> s_rd_pulse ##1 (state_r == esdp_pkg::ST_IDLE))
    else $error("read strobe sequence wrong");

  chk_read_pin_pulse: assert property ( // R3
    start_rd |-> ##3 (socket_b_strobe_pin_out == ctrl_r[esdp_pkg::POL_BIT]) [*5])
    else $error("socket B pin not asserted during read strobe");

  chk_write_latch_copy: assert property ( // R4
    start_wr |=> (latch_r == $past(bus_req.wdata)) and s_wr_pulse)
    else $error("write port did not strobe or keep latch copy");

  chk_write_data_drive: assert property ( // R4
    start_wr |-> ##2 (sd_hi_oe && sd_hi_out == $past(bus_req.wdata, 2)) [*4])
    else $error("upper byte not driven around write strobe");

  chk_strobe_polarity: assert property ( // R5
    ($past(act_b) && $past(out_b)) |-> (socket_b_strobe_pin_out == $past(ctrl_r[esdp_pkg::POL_BIT])))
    else $error("strobe level does not follow polarity");

  chk_a_pin_sense: assert property ( // R6
    $past(!ctrl_r[esdp_pkg::WSE_BIT]) |-> !socket_a_strobe_pin_oe)
    else $error("socket A pin driven while sensing");

  chk_b_pin_sense: assert property ( // R7
    $past(!ctrl_r[esdp_pkg::WSE_BIT] && !ctrl_r[esdp_pkg::RSE_BIT]) |-> !socket_b_strobe_pin_oe)
    else $error("socket B pin driven while sensing");

  chk_pullup_forced_off: assert property ( // R8
    $past(ctrl_r[esdp_pkg::WSE_BIT]) |-> !socket_a_strobe_pullup)
    else $error("socket A pull-up on with strobe enabled");

  chk_open_collector: assert property ( // R9
    $past(!ctrl_r[esdp_pkg::DRV_BIT]) |-> !(socket_a_strobe_pin_oe && socket_a_strobe_pin_out))
    else $error("open-collector strobe drove high");

  chk_timing_now: assert property ( // R10
    tm_hit(1) && !sel_set1 |=> (cycle_timing.command == $past(bus_req.wdata)))
    else $error("timing write not effective at once");

  chk_timing_select: assert property ( // R12
    cycle_timing.command == (($past(cycle_window) ? winctl_r[esdp_pkg::WIN1_SEL_BIT]
                                                  : winctl_r[esdp_pkg::WIN0_SEL_BIT]) ? tm_r[4] : tm_r[1]))
    else $error("wrong timing set selected");

  chk_reserved_quiet: assert property ( // R15
    (mode == esdp_pkg::MODE_RSVD && state_r == esdp_pkg::ST_IDLE) |=> (state_r == esdp_pkg::ST_IDLE))
    else $error("strobe started in reserved mode");

endmodule

//--- tb/esdp_ext_model.sv
// ----------------------------------------
// Partner model: external latch and read buffer on the upper data byte
// ----------------------------------------
// Assumes the socket B strobe wire level and the polarity come from the bench.
`timescale 1ns/100ps
module esdp_ext_model (
  // Clock
  clk_sys,
  // Strobe and control
  strobe_lvl,
  pol_high,
  slow,
  buf_val,
  // Upper data byte
  sd_out,
  sd_oe,
  sd_in,
  latch_r,
  pulses
);
  input wire logic clk_sys;
  input wire logic strobe_lvl;
  input wire logic pol_high;
  input wire logic slow;
  input wire logic [7:0] buf_val;
  input wire logic [7:0] sd_out;
  input wire logic sd_oe;
  output logic [7:0] sd_in;
  output logic [7:0] latch_r;
  output int pulses;
  logic act;
  logic act_d;
  logic [7:0] last_r;
  assign act = (strobe_lvl == pol_high);
  // Buffer drives only while enabled; a slow buffer is late by one cycle
  always_comb begin
    if (act && !sd_oe && !(slow && !act_d)) begin
      sd_in = buf_val;
    end else begin
      sd_in = ~last_r;
    end
  end
  // Latch follows the byte while strobed, then holds; count strobe pulses
  always @(posedge clk_sys) begin
    act_d <= act;
    last_r <= sd_in;
    if (act && sd_oe) begin
      latch_r <= sd_out;
    end
    if (act && !act_d) begin
      pulses <= pulses + 1;
    end
  end
  // Start state of the board parts
  initial begin
    pulses = 0;
    latch_r = 8'h00;
    act_d = 1'h0;
    last_r = 8'h00;
  end
endmodule

//--- tb/test_esdp_top.sv
// ----------------------------------------
// Testbench of the external strobe data port
// ----------------------------------------
// Assumes the partner model on the upper data byte and socket B strobe.
`timescale 1ns/100ps
module test_esdp_top;
  logic clk_sys, sys_rst, ce, cycle_window, slow, rd_q, pol;
  logic a1, a2, b1, b2, a_lvl, b_lvl;
  logic sd_oe, a_out, a_oe, a_pu, b_out, b_oe, b_pu;
  logic [7:0] rdata, sd_out, sd_in, buf_val, latch, d, v;
  esdp_pkg::esdp_req_t req;
  esdp_pkg::esdp_timing_t tmg;
  logic [7:0] exp_q[$];
  int num_errors, check_count, cycles, pulses, p0;
  esdp_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .bus_req(req), .rdata(rdata),
    .sd_hi_in(sd_in), .sd_hi_out(sd_out), .sd_hi_oe(sd_oe), .socket_a_strobe_pin_in(a_lvl),
    .socket_a_strobe_pin_out(a_out), .socket_a_strobe_pin_oe(a_oe), .socket_a_strobe_pullup(a_pu),
    .socket_b_strobe_pin_in(b_lvl), .socket_b_strobe_pin_out(b_out), .socket_b_strobe_pin_oe(b_oe),
    .socket_b_strobe_pullup(b_pu), .socket_a_sense_two_n(a2), .socket_b_sense_two_n(b2),
    .cycle_window(cycle_window), .cycle_timing(tmg));
  esdp_ext_model u_ext (.clk_sys(clk_sys), .strobe_lvl(b_lvl), .pol_high(pol), .slow(slow),
    .buf_val(buf_val), .sd_out(sd_out), .sd_oe(sd_oe), .sd_in(sd_in), .latch_r(latch), .pulses(pulses));
  // Pin wires: driven level when enabled, else sense level or board resistor
  assign a_lvl = a_oe ? a_out : a1;
  assign b_lvl = b_oe ? b_out : b1;
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: w, wr: 1'h1, rd: 1'h0};
    if (a == 8'h0b) begin
      pol <= w[5];
    end
    @(posedge clk_sys);
    req.wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge clk_sys);
    req.rd <= 1'h0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Clock of 100 ns
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Read monitor: each answer is compared with the oldest expectation
  always @(posedge clk_sys) begin
    if (rd_q) begin
      check_byte(rdata, exp_q.pop_front());
    end
    rd_q <= sys_rst ? 1'h0 : req.rd;
  end
  // Cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test;
    end
  end
  // Main sequence
  initial begin
    {sys_rst, ce, a1, b1} = 4'hf;
    {cycle_window, slow, pol, a2, b2} = 5'h00;
    req = '0;
    buf_val = 8'h00;
    void'($urandom(32'hef2d));
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'h0;
    settle(1);
    check_byte(tmg.command, esdp_pkg::CMD0_RST);
    check_byte(tmg.recovery, esdp_pkg::RECOV_RST);
    rd(8'h0b, 8'h00);
    rd(8'h55, 8'h00);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      {a1, a2, b1, b2} <= 4'($urandom);
      d = 8'($urandom);
      wr(8'h0a, d);
      settle(4);
      rd(8'h0a, {d[7:4], b2, b1, a2, a1});
    end
    @(posedge clk_sys);
    {a1, b1} <= 2'h3;
    wr(8'h0b, 8'hc3);
    rd(8'h0b, 8'hc3);
    wr(8'h0b, 8'hd8);
    wr(8'h03, 8'h20);
    settle(4);
    p0 = pulses;
    check_byte(8'({a_pu, b_pu}), 8'h00);
    rd(8'h0a, {d[7:4], b2, 1'h1, a2, 1'h1});
    settle(10);
    check_byte(8'(pulses - p0), 8'h00);
    wr(8'h0b, 8'h00);
    settle(2);
    check_byte(8'({a_pu, b_pu, a_oe, b_oe}), 8'h0c);
    $display("scratchpad test done");
    wr(8'h0b, 8'h08);
    settle(2);
    check_byte(8'({b_pu, b_oe, a_pu, a_oe}), 8'h02);
    p0 = pulses;
    v = 8'h00;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      buf_val <= 8'($urandom);
      slow <= k[0];
      rd(8'h0a, v);
      v = buf_val;
      settle(8);
    end
    check_byte(8'(pulses - p0), 8'h03);
    wr(8'h0b, 8'h0c);
    settle(2);
    check_byte(8'({b_out, b_oe}), 8'h03);
    $display("read port test done");
    wr(8'h0b, 8'h30);
    settle(2);
    check_byte(8'({a_out, a_oe, a_pu}), 8'h02);
    d = 8'($urandom);
    p0 = pulses;
    wr(8'h0a, d);
    settle(8);
    check_byte(latch, d);
    check_byte(8'(pulses - p0), 8'h01);
    rd(8'h0a, d);
    $display("write port test done");
    v = 8'($urandom);
    wr(8'h3a, v);
    settle(0);
    check_byte(tmg.setup, v);
    wr(8'h3b, ~v);
    settle(0);
    check_byte(tmg.command, ~v);
    wr(8'h3d, ~v);
    wr(8'h07, 8'h08);
    settle(1);
    check_byte(tmg.setup, ~v);
    @(posedge clk_sys);
    cycle_window <= 1'h1;
    settle(2);
    check_byte(tmg.setup, v);
    wr(8'h07, 8'h80);
    settle(1);
    check_byte(tmg.command, esdp_pkg::CMD1_RST);
    @(posedge clk_sys);
    ce <= 1'h0;
    wr(8'h3d, v);
    @(posedge clk_sys);
    ce <= 1'h1;
    settle(1);
    check_byte(tmg.setup, ~v);
    $display("timing test done");
    end_of_test;
  end
endmodule
